// file: clock_monitor_status_flags_test.sv
// Self-checking bench for the clock monitor status bank.
// Assumes monitor levels may be driven directly; the host model does all reads.
`timescale 1ns/1ps
`default_nettype none

`include "cms_defs.svh"

module clock_monitor_status_flags_test
	import cms_pkg::*;
	;

	localparam int MAX_CYCLES = 3000;

	logic       mclk;
	logic       reset;
	logic       clk_en;
	cms_fault_s mon_fault;
	cms_warn_s  mon_warn;
	logic       rd_strobe;
	cms_byte_t  rd_index;
	cms_byte_t  rd_data_ff;
	logic       rd_valid_ff;
	logic       sysclk_fault_mirror;
	int         n_fail      = 0;
	int         comparisons = 0;
	int         cycles      = 0;
	cms_byte_t  a;
	cms_byte_t  b;

	initial mclk = 1'b0;
	always #12.5 mclk = ~mclk;

	cms_status_regs uut (
		.mclk                (mclk),
		.reset               (reset),
		.clk_en              (clk_en),
		.mon_fault           (mon_fault),
		.mon_warn            (mon_warn),
		.rd_strobe           (rd_strobe),
		.rd_index            (rd_index),
		.rd_data_ff          (rd_data_ff),
		.rd_valid_ff         (rd_valid_ff),
		.sysclk_fault_mirror (sysclk_fault_mirror)
	);

	cms_host_model host (
		.mclk        (mclk),
		.rd_valid_ff (rd_valid_ff),
		.rd_data_ff  (rd_data_ff),
		.rd_strobe   (rd_strobe),
		.rd_index    (rd_index)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick

	task automatic check(input cms_byte_t got, input cms_byte_t exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test

	// Hang guard: a run far past the expected length counts as a mismatch
	always @(posedge mclk) begin
		cycles++;
		if (cycles == MAX_CYCLES) begin
			n_fail++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		host.read(`CMS_IDX_FAULT, a);
		check(a, 8'h00, "fault reset");
		host.read(`CMS_IDX_WARN, a);
		check(a, 8'h00, "warn reset");
		host.read(8'h02, a);
		check(a, 8'h00, "unmapped");
		$display("test reset done");
	endtask : test_reset

	// Each cause pulses, then goes away before the read
	task automatic test_fault_bits();
		cms_byte_t exp [7] = '{8'h80, 8'h81, 8'h04, 8'h08, 8'h10, 8'h40, 8'h02};
		for (int i = 0; i < 7; i++) begin
			mon_fault = cms_fault_s'(7'h40 >> i);
			tick(5);
			mon_fault = '0;
			tick(4);
			check({7'h00, sysclk_fault_mirror}, {7'h00, exp[i][7]}, "mirror set");
			host.read_confirm(`CMS_IDX_FAULT, a, b);
			check(a, exp[i], "fault bit");
			check(b, 8'h00, "fault cleared");
			check({7'h00, sysclk_fault_mirror}, 8'h00, "mirror clear");
		end
		$display("test fault bits done");
	endtask : test_fault_bits

	task automatic test_warn_bits();
		cms_byte_t exp [5] = '{8'h04, 8'h08, 8'h10, 8'h40, 8'h02};
		for (int i = 0; i < 5; i++) begin
			mon_warn = cms_warn_s'(5'h10 >> i);
			tick(5);
			mon_warn = '0;
			tick(4);
			host.read_confirm(`CMS_IDX_WARN, a, b);
			check(a, exp[i], "warn bit");
			check(b, 8'h00, "warn cleared");
		end
		$display("test warn bits done");
	endtask : test_warn_bits

	// A read with the cause still live must not lose the flag
	task automatic test_persist();
		mon_fault.step_up = 1'b1;
		tick(5);
		host.read_confirm(`CMS_IDX_FAULT, a, b);
		check(a, 8'h40, "live first");
		check(b, 8'h40, "live kept");
		mon_fault.step_up = 1'b0;
		tick(4);
		host.read_confirm(`CMS_IDX_FAULT, a, b);
		check(a, 8'h40, "held");
		check(b, 8'h00, "cleared");
		$display("test persist done");
	endtask : test_persist

	// Reading one register leaves the other alone; reserved bits stay zero
	task automatic test_cross();
		mon_fault = '1;
		mon_warn  = '1;
		tick(5);
		mon_fault = '0;
		mon_warn  = '0;
		tick(4);
		host.read_confirm(`CMS_IDX_WARN, a, b);
		check(a, 8'h5E, "warn all");
		check(b, 8'h00, "warn empty");
		host.read_confirm(`CMS_IDX_FAULT, a, b);
		check(a, 8'hDF, "fault kept");
		check(b, 8'h00, "fault empty");
		$display("test cross done");
	endtask : test_cross

	// Clock enable low freezes synchronisers and flags, so a cause seen only then is lost
	task automatic test_freeze();
		clk_en = 1'b0;
		mon_fault.sys_analog = 1'b1;
		tick(6);
		check({7'h00, sysclk_fault_mirror}, 8'h00, "frozen mirror");
		mon_fault = '0;
		tick(2);
		clk_en = 1'b1;
		tick(4);
		host.read(`CMS_IDX_FAULT, a);
		check(a, 8'h00, "frozen flags");
		$display("test freeze done");
	endtask : test_freeze

	initial begin
		reset     = 1'b1;
		clk_en    = 1'b1;
		mon_fault = '0;
		mon_warn  = '0;
		repeat (4) @(posedge mclk);
		#1;
		reset = 1'b0;
		test_reset();
		test_fault_bits();
		test_warn_bits();
		test_persist();
		test_cross();
		test_freeze();
		finish_test();
	end

endmodule : clock_monitor_status_flags_test

`default_nettype wire

// file: cms_defs.svh
// Offsets, field positions, reset values and masks of the clock monitor status bank.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ----------------------------------------
// Register indices on the read port
// ----------------------------------------
`define CMS_IDX_FAULT        8'h00
`define CMS_IDX_WARN         8'h01

// ----------------------------------------
// Fault register fields
// ----------------------------------------
`define CMS_F_COMBINED_SYS   7
`define CMS_F_STEP_UP        6
`define CMS_F_LV_STEPDOWN    4
`define CMS_F_PREREG         3
`define CMS_F_SYNC_IN        2
`define CMS_F_SW_SOURCE      1
`define CMS_F_DIGITAL_SYS    0

// ----------------------------------------
// Warning register fields
// ----------------------------------------
`define CMS_W_STEP_UP        6
`define CMS_W_LV_STEPDOWN    4
`define CMS_W_PREREG         3
`define CMS_W_SYNC_IN        2
`define CMS_W_SW_SOURCE      1

// ----------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------
`define CMS_FAULT_RESET      8'h00
`define CMS_WARN_RESET       8'h00
`define CMS_FAULT_MASK       8'hDF
`define CMS_WARN_MASK        8'h5E
`define CMS_UNMAPPED_DATA    8'h00

`endif

// file: cms_flag_cell.sv
// Bank of sticky flags that clear on a read once their cause has gone.
// Assumes the clear pulse is synchronous to mclk and one cycle wide.
`timescale 1ns/1ps
`default_nettype none

module cms_flag_cell #(
	parameter int         W         = 8,
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] cond,
	input  wire logic         rd_clear,
	output logic      [W-1:0] flags_ff
);

	logic [W-1:0] nxt_flags;

	// [RULE15] Set beats clear
	// A live cause always wins over the clearing read
	always_comb begin
		nxt_flags = cond | (rd_clear ? '0 : flags_ff);
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			flags_ff <= RESET_VAL[W-1:0];
		end else if (clk_en) begin
			flags_ff <= nxt_flags;
		end
	end

endmodule : cms_flag_cell

`default_nettype wire

// file: cms_host_model.sv
// Host controller model that reads the clock monitor status bank byte by byte.
// Assumes the bank takes a strobe on a rising mclk edge and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none

module cms_host_model
	import cms_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      rd_valid_ff,
	input  wire cms_byte_t rd_data_ff,
	output logic           rd_strobe,
	output cms_byte_t      rd_index
);

	initial begin
		rd_strobe = 1'b0;
		rd_index  = 8'h00;
	end

	// ----------------------------------------
	// Read access
	// ----------------------------------------
	// Index is scrambled once taken, so a late sample of it cannot look right
	task automatic read(input cms_byte_t idx, output cms_byte_t data);
		@(posedge mclk) #1;
		rd_strobe = 1'b1;
		rd_index  = idx;
		@(posedge mclk) #1;
		rd_strobe = 1'b0;
		rd_index  = ~idx;
		data      = (rd_valid_ff === 1'b1) ? rd_data_ff : 8'hXX;
	endtask : read

	task automatic read_confirm(input cms_byte_t idx, output cms_byte_t first, output cms_byte_t second);
		read(idx, first);
		read(idx, second);
	endtask : read_confirm

endmodule : cms_host_model

`default_nettype wire

// file: cms_pkg.sv
// Types shared by the clock monitor status bank.
// Assumes the constants header is compiled alongside.
`default_nettype none

package cms_pkg;

	// Raw fault levels from the monitor circuits
	typedef struct packed {
		logic sys_analog;
		logic sys_digital;
		logic sync_in;
		logic prereg;
		logic lv_stepdown;
		logic step_up;
		logic sw_source;
	} cms_fault_s;

	// Raw accuracy warning levels
	typedef struct packed {
		logic sync_in;
		logic prereg;
		logic lv_stepdown;
		logic step_up;
		logic sw_source;
	} cms_warn_s;

	typedef logic [7:0] cms_byte_t;

endpackage : cms_pkg

`default_nettype wire

// file: cms_status_regs.sv
// Clock monitor fault and accuracy warning status registers.
// Assumes a serial-interface decoder on mclk issues one-cycle read strobes
// and that monitor levels arrive from other domains and need synchronising.
`timescale 1ns/1ps
`default_nettype none

`include "cms_defs.svh"

// How it works
// [RULE1] A flag set by a monitor stays one until its register is read.
// [RULE2] A read clears set flags whose condition is gone; persisting ones stay.
// [RULE3] Host reads again after a clearing read to confirm the condition ended.
// [RULE4] Both registers reset to zero and change only through monitors and reads.
// [RULE5] Fault bit 7 sets on analog or digital system clock error.
// [RULE6] Fault bit 7 is mirrored out and cleared by a fault register read.
// [RULE7] Fault bit 6 follows monitor five, step-up switching clock.
// [RULE8] Fault bit 4 follows monitor four, low-voltage step-down clock.
// [RULE9] Fault bit 3 follows monitor three, preregulator switching clock.
// [RULE10] Fault bit 2 follows monitor one, external sync input.
// [RULE11] Fault bit 1 follows monitor six, switching-source clock.
// [RULE12] Fault bit 0 follows monitor two only, ignoring the analog monitor.
// [RULE13] Warning bits 6,4,3,2,1 come from the matching monitors.
// [RULE14] Reserved bits of both registers always read zero.
// [RULE15] A cause arriving with the clearing read keeps the flag set.
module cms_status_regs
	import cms_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic       clk_en,
	input  wire cms_fault_s mon_fault,
	input  wire cms_warn_s  mon_warn,
	input  wire logic       rd_strobe,
	input  wire cms_byte_t  rd_index,
	output cms_byte_t       rd_data_ff,
	output logic            rd_valid_ff,
	output logic            sysclk_fault_mirror
);

	// ----------------------------------------
	// Mapping functions
	// ----------------------------------------
	function automatic cms_byte_t fault_vector(input cms_fault_s f);
		cms_byte_t v;
		v = 8'h00;
		v[`CMS_F_COMBINED_SYS] = f.sys_analog | f.sys_digital;
		// [RULE7] Step-up monitor five
		v[`CMS_F_STEP_UP]      = f.step_up;
		// [RULE8] Step-down monitor four
		v[`CMS_F_LV_STEPDOWN]  = f.lv_stepdown;
		// [RULE9] Preregulator monitor three
		v[`CMS_F_PREREG]       = f.prereg;
		// [RULE10] Sync monitor one
		v[`CMS_F_SYNC_IN]      = f.sync_in;
		// [RULE11] Source monitor six
		v[`CMS_F_SW_SOURCE]    = f.sw_source;
		v[`CMS_F_DIGITAL_SYS]  = f.sys_digital;
		return v & `CMS_FAULT_MASK;
	endfunction : fault_vector

	function automatic cms_byte_t warn_vector(input cms_warn_s w);
		cms_byte_t v;
		v = 8'h00;
		// [RULE13] Matching monitor bits
		v[`CMS_W_STEP_UP]     = w.step_up;
		v[`CMS_W_LV_STEPDOWN] = w.lv_stepdown;
		v[`CMS_W_PREREG]      = w.prereg;
		v[`CMS_W_SYNC_IN]     = w.sync_in;
		v[`CMS_W_SW_SOURCE]   = w.sw_source;
		return v & `CMS_WARN_MASK;
	endfunction : warn_vector

	// ----------------------------------------
	// Monitor input synchronisers
	// ----------------------------------------
	cms_fault_s fault_s;
	cms_warn_s  warn_s;

	cms_sync #(
		.W ($bits(cms_fault_s))
	) u_sync_fault (
		.mclk     (mclk),
		.reset    (reset),
		.clk_en   (clk_en),
		.async_in (mon_fault),
		.sync_out (fault_s)
	);

	cms_sync #(
		.W ($bits(cms_warn_s))
	) u_sync_warn (
		.mclk     (mclk),
		.reset    (reset),
		.clk_en   (clk_en),
		.async_in (mon_warn),
		.sync_out (warn_s)
	);

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	logic rd_fault;
	logic rd_warn;

	assign rd_fault = rd_strobe & (rd_index == `CMS_IDX_FAULT);
	assign rd_warn  = rd_strobe & (rd_index == `CMS_IDX_WARN);

	// ----------------------------------------
	// Sticky flag banks
	// ----------------------------------------
	cms_byte_t fault_cond;
	cms_byte_t warn_cond;
	cms_byte_t fault_ff;
	cms_byte_t warn_ff;

	// [RULE5] System clock fault OR
	// [RULE12] Digital-only bit mapping
	assign fault_cond = fault_vector(fault_s);
	// [RULE13] Warning bit mapping
	assign warn_cond  = warn_vector(warn_s);

	// [RULE1] Sticky until read
	// [RULE2] Clear only causes gone
	cms_flag_cell #(
		.W         (8),
		.RESET_VAL (`CMS_FAULT_RESET)
	) u_fault_flags (
		.mclk     (mclk),
		.reset    (reset),
		.clk_en   (clk_en),
		.cond     (fault_cond),
		.rd_clear (rd_fault),
		.flags_ff (fault_ff)
	);

	// [RULE4] Zero at power-on reset
	cms_flag_cell #(
		.W         (8),
		.RESET_VAL (`CMS_WARN_RESET)
	) u_warn_flags (
		.mclk     (mclk),
		.reset    (reset),
		.clk_en   (clk_en),
		.cond     (warn_cond),
		.rd_clear (rd_warn),
		.flags_ff (warn_ff)
	);

	// [RULE6] Replica for off-state register
	assign sysclk_fault_mirror = fault_ff[`CMS_F_COMBINED_SYS];

	// ----------------------------------------
	// Read data return
	// ----------------------------------------
	// Data shows the flags as they were before the clearing edge,
	// so a single read never loses a latched event.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_data_ff <= `CMS_UNMAPPED_DATA;
		end else if (clk_en && rd_strobe) begin
			// [RULE14] Reserved bits masked
			if (rd_fault) begin
				rd_data_ff <= fault_ff & `CMS_FAULT_MASK;
			end else if (rd_warn) begin
				rd_data_ff <= warn_ff & `CMS_WARN_MASK;
			end else begin
				rd_data_ff <= `CMS_UNMAPPED_DATA;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rd_valid_ff <= 1'b0;
		end else if (clk_en) begin
			rd_valid_ff <= rd_strobe;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	sequence s_fault_read;
		clk_en && rd_fault;
	endsequence

	sequence s_warn_read;
		clk_en && rd_warn;
	endsequence

	sequence s_no_fault_read;
		clk_en && !rd_fault;
	endsequence

	// [RULE1] Set fault flags held
	a_fault_held_unread: assert property (s_no_fault_read |=> (fault_ff & $past(fault_ff)) == $past(fault_ff)) // [RULE1]
		else $error("fault flag dropped without a read");

	// [RULE1] Set warning flags held
	a_warn_held_unread: assert property (clk_en && !rd_warn |=> (warn_ff & $past(warn_ff)) == $past(warn_ff)) // [RULE1]
		else $error("warning flag dropped without a read");

	// [RULE2] Fault read leaves live causes
	a_fault_read_clear: assert property (s_fault_read |=> fault_ff == $past(fault_cond)) // [RULE2]
		else $error("fault read did not clear to live causes");

	// [RULE2] Warning read leaves live causes
	a_warn_read_clear: assert property (s_warn_read |=> warn_ff == $past(warn_cond)) // [RULE2]
		else $error("warning read did not clear to live causes");

	// [RULE2] Second read confirms clear
	a_read_twice_gone: assert property (s_fault_read ##2 (clk_en && rd_fault && fault_cond == 8'h00) // [RULE2]
		|=> fault_ff == 8'h00)
		else $error("fault flags stayed after read with no causes");

	// [RULE4] Zero during reset
	a_reset_zero_regs: assert property (disable iff (1'b0) reset |-> fault_ff == 8'h00 && warn_ff == 8'h00) // [RULE4]
		else $error("status registers not zero in reset");

	// [RULE4] Frozen while disabled
	a_freeze_no_enable: assert property (!clk_en |=> $stable(fault_ff) && $stable(warn_ff) && $stable(rd_data_ff)) // [RULE4]
		else $error("state changed with clock enable low");

	// [RULE5] System clock fault from either monitor
	a_sysclk_either_mon: assert property (clk_en && (fault_s.sys_analog || fault_s.sys_digital) // [RULE5]
		|=> fault_ff[`CMS_F_COMBINED_SYS])
		else $error("system clock fault bit not set");

	// [RULE6] Mirror follows bit and clears by read
	a_mirror_read_clear: assert property (s_fault_read ##0 (!fault_s.sys_analog && !fault_s.sys_digital) // [RULE6]
		|=> !sysclk_fault_mirror)
		else $error("system clock mirror not cleared by read");

	// [RULE7] Step-up fault bit
	a_step_up_fault: assert property (clk_en && fault_s.step_up |=> fault_ff[`CMS_F_STEP_UP]) // [RULE7]
		else $error("step-up fault bit not set");

	// [RULE8] Step-down fault bit
	a_lv_stepdown_fault: assert property (clk_en && fault_s.lv_stepdown |=> fault_ff[`CMS_F_LV_STEPDOWN]) // [RULE8]
		else $error("step-down fault bit not set");

	// [RULE9] Preregulator fault bit
	a_prereg_fault: assert property (clk_en && fault_s.prereg |=> fault_ff[`CMS_F_PREREG]) // [RULE9]
		else $error("preregulator fault bit not set");

	// [RULE10] Sync input fault bit
	a_sync_in_fault: assert property (clk_en && fault_s.sync_in |=> fault_ff[`CMS_F_SYNC_IN]) // [RULE10]
		else $error("sync input fault bit not set");

	// [RULE11] Switching source fault bit
	a_sw_source_fault: assert property (clk_en && fault_s.sw_source |=> fault_ff[`CMS_F_SW_SOURCE]) // [RULE11]
		else $error("switching source fault bit not set");

	// [RULE12] Analog monitor never reaches bit 0
	a_digital_only_bit: assert property (s_fault_read ##0 !fault_s.sys_digital // [RULE12]
		|=> !fault_ff[`CMS_F_DIGITAL_SYS])
		else $error("digital system clock bit set without monitor two");

	// [RULE13] Warning bits follow monitors
	a_warn_bits_map: assert property (clk_en |=> (warn_ff & $past(warn_cond)) == $past(warn_cond) // [RULE13]
		&& $past(warn_cond[`CMS_W_STEP_UP]) == $past(warn_s.step_up))
		else $error("warning bit missing for live cause");

	// [RULE14] Reserved bits zero
	a_reserved_bits_zero: assert property ((fault_ff & ~`CMS_FAULT_MASK) == 8'h00 // [RULE14]
		&& (warn_ff & ~`CMS_WARN_MASK) == 8'h00)
		else $error("reserved status bit set");

	// [RULE14] Read data from latched flags
	a_read_data_value: assert property (s_fault_read |=> rd_valid_ff && rd_data_ff == $past(fault_ff)) // [RULE14]
		else $error("fault read data wrong");

	// [RULE15] Cause beats clearing read
	a_set_wins_clear: assert property (s_fault_read ##0 fault_s.step_up |=> fault_ff[`CMS_F_STEP_UP]) // [RULE15]
		else $error("event lost in clearing read");

	// [RULE12] Analog alone misses bit 0
	a_analog_not_bit0: assert property (clk_en && !fault_s.sys_digital && !fault_ff[`CMS_F_DIGITAL_SYS] // [RULE12]
		|=> !fault_ff[`CMS_F_DIGITAL_SYS])
		else $error("digital system clock bit set by another monitor");

	// [RULE6] Mirror rises with analog fault
	a_mirror_sets: assert property (clk_en && fault_s.sys_analog |=> sysclk_fault_mirror) // [RULE6]
		else $error("system clock mirror not set");

	// [RULE14] Warning read data from flags
	a_warn_data_value: assert property (s_warn_read |=> rd_valid_ff && rd_data_ff == $past(warn_ff)) // [RULE14]
		else $error("warning read data wrong");

	// [RULE14] Unmapped index reads zero
	a_unmapped_zero: assert property (clk_en && rd_strobe && !rd_fault && !rd_warn // [RULE14]
		|=> rd_valid_ff && rd_data_ff == `CMS_UNMAPPED_DATA)
		else $error("unmapped read returned data");

	// [RULE4] No answer without a read
	a_valid_needs_read: assert property (clk_en && !rd_strobe |=> !rd_valid_ff) // [RULE4]
		else $error("read valid without a read strobe");

endmodule : cms_status_regs

`default_nettype wire

// file: cms_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes the levels are quasi-static relative to mclk.
`timescale 1ns/1ps
`default_nettype none

module cms_sync #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic         clk_en,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (clk_en) begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;

endmodule : cms_sync

`default_nettype wire
